// ==== logic/atasf_core.sv ====
// sense-condition and set-features command decoder with an ahb-lite register slave
// assumes temperature in signed whole degrees from a sensor on hclk, reassign_full a pin
`timescale 1ns/10ps
module atasf_core (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire atasf_pkg::atasf_ahb_in_t ahb,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic signed [9:0]      temp_deg,
    input  wire logic                   reassign_full,
    output atasf_pkg::atasf_feat_t      feat,
    output logic                        spinup_req,
    output logic                        cmd_done
);
    import atasf_pkg::*;

    typedef enum logic [1:0] {IDLE, EXEC, DONE} atasf_state_t;

    typedef struct packed {
        atasf_state_t state;
        logic         ph_wr;
        logic [7:0]   ph_addr;
        logic [7:0]   opc;
        logic [7:0]   fea;
        logic [7:0]   cnt;
        logic [7:0]   err;
        logic [7:0]   stat;
        logic [7:0]   result;
        logic [31:0]  sectime;
        logic [31:0]  rdata;
        logic         full_s1;
        logic         full_s2;
        logic         wc_locked;
        logic         spin;
        logic         done;
        atasf_feat_t  f;
    } atasf_regs_t;

    atasf_regs_t r;
    atasf_regs_t next_r;

    // temperature to sector-count code
    function automatic logic [7:0] temp_code(input logic signed [9:0] t);
        logic signed [11:0] c;
        c = 12'(2 * (int'(t) + ATASF_TEMP_OFS));
        if (int'(t) <= -ATASF_TEMP_OFS)
            temp_code = ATASF_TEMP_LOW;
        else if (int'(t) > ATASF_TEMP_MAX)
            temp_code = ATASF_TEMP_HIGH;
        else if (c > 12'sd254)
            temp_code = 8'hfe;
        else
            temp_code = c[7:0];
    endfunction : temp_code

    // transfer-mode encoding check
    function automatic logic xfer_ok(input logic [7:0] sc);
        logic [4:0] ty;
        logic [2:0] md;
        ty = sc[7:3];
        md = sc[2:0];
        case (ty)
            ATASF_XT_PIO:  xfer_ok = (md <= ATASF_PIO_MAX);
            ATASF_XT_FPIO: xfer_ok = (md <= ATASF_FPIO_MAX);
            ATASF_XT_MDMA: xfer_ok = (md <= ATASF_MDMA_MAX);
            ATASF_XT_UDMA: xfer_ok = (md <= ATASF_UDMA_MAX);
            default:       xfer_ok = 1'b0;
        endcase
    endfunction : xfer_ok

    logic wr_cmd;
    assign wr_cmd = r.ph_wr && (r.ph_addr == ATASF_OFS_COMMAND);

    // next-state logic: bus, command decode, feature state
    always_comb begin
        logic abort;
        abort = 1'b0;
        next_r = r;
        next_r.full_s1 = reassign_full;
        next_r.full_s2 = r.full_s1;
        next_r.spin = 1'b0;
        next_r.done = 1'b0;
        next_r.ph_wr = 1'b0;
        // address phase capture
        if (ahb.hsel && ahb.hready && ahb.htrans[1]) begin
            next_r.ph_wr = ahb.hwrite;
            next_r.ph_addr = ahb.haddr[7:0];
            case (ahb.haddr[7:0])
                ATASF_OFS_ERROR:    next_r.rdata = {24'h0, r.err};
                ATASF_OFS_STATUS:   next_r.rdata = {24'h0, r.stat};
                ATASF_OFS_RESULT:   next_r.rdata = {24'h0, r.result};
                ATASF_OFS_FEATURES: next_r.rdata = {8'h0, r.f.sata_code, r.f.apm_level, r.f.write_cache,
                                        r.f.look_ahead, r.f.revert_defaults, r.f.release_irq,
                                        r.f.power_mgmt, r.f.standby_powerup, r.f.sata_option,
                                        r.f.epc_select};
                ATASF_OFS_XFER:     next_r.rdata = {24'h0, r.f.xfer_mode};
                ATASF_OFS_SECTIME:  next_r.rdata = r.sectime;
                default:            next_r.rdata = 32'h0;
            endcase
        end
        if (r.ph_wr && (r.ph_addr == ATASF_OFS_SECTIME))
            next_r.sectime = ahb.hwdata;
        // reassignment capacity exhausted turns cache off until reset
        if (r.full_s2) begin
            next_r.wc_locked = 1'b1;
            next_r.f.write_cache = 1'b0;
        end
        case (r.state)
            IDLE: begin
                if (wr_cmd) begin
                    next_r.opc = ahb.hwdata[ATASF_OPC_LSB +: 8];
                    next_r.fea = ahb.hwdata[ATASF_FEA_LSB +: 8];
                    next_r.cnt = ahb.hwdata[ATASF_CNT_LSB +: 8];
                    next_r.stat = 8'h0;
                    next_r.stat[ATASF_ST_BSY] = 1'b1;
                    next_r.state = EXEC;
                end
            end
            EXEC: begin
                next_r.err = 8'h0;
                if (r.opc == ATASF_OPC_SENSE) begin
                    if (r.fea == ATASF_SENSE_FEA)
                        next_r.result = temp_code(temp_deg);
                    else
                        abort = 1'b1;
                end else if (r.opc == ATASF_OPC_SETF) begin
                    case (r.fea)
                        ATASF_F_WC_ON:    next_r.f.write_cache = ~(r.wc_locked | r.full_s2);
                        ATASF_F_WC_OFF:   next_r.f.write_cache = 1'b0;
                        ATASF_F_XFER: begin
                            if (xfer_ok(r.cnt))
                                next_r.f.xfer_mode = r.cnt;
                            else
                                abort = 1'b1;
                        end
                        ATASF_F_APM_ON: begin
                            next_r.f.power_mgmt = 1'b1;
                            next_r.f.apm_level = r.cnt;
                        end
                        ATASF_F_APM_OFF:  next_r.f.power_mgmt = 1'b0;
                        ATASF_F_PUIS_ON:  next_r.f.standby_powerup = 1'b1;
                        ATASF_F_PUIS_OFF: next_r.f.standby_powerup = 1'b0;
                        ATASF_F_SPINUP:   next_r.spin = 1'b1;
                        ATASF_F_SATA_ON: begin
                            next_r.f.sata_option = 1'b1;
                            next_r.f.sata_code = r.cnt;
                        end
                        ATASF_F_SATA_OFF: begin
                            next_r.f.sata_option = 1'b0;
                            next_r.f.sata_code = r.cnt;
                        end
                        ATASF_F_SECTIME:  next_r.sectime[7:0] = r.cnt;
                        ATASF_F_EPC:      next_r.f.epc_select = 1'b1;
                        ATASF_F_RLA_OFF:  next_r.f.look_ahead = 1'b0;
                        ATASF_F_RLA_ON:   next_r.f.look_ahead = 1'b1;
                        ATASF_F_REV_OFF:  next_r.f.revert_defaults = 1'b0;
                        ATASF_F_REV_ON:   next_r.f.revert_defaults = 1'b1;
                        default:          abort = 1'b1;
                    endcase
                end else begin
                    abort = 1'b1;
                end
                next_r.err[ATASF_ERR_ABT] = abort;
                next_r.stat = 8'h0;
                next_r.stat[ATASF_ST_RDY] = 1'b1;
                next_r.stat[ATASF_ST_ERR] = abort;
                next_r.done = 1'b1;
                next_r.state = DONE;
            end
            DONE:    next_r.state = IDLE;
            default: next_r.state = IDLE;
        endcase
        // late lock in the same cycle still wins over an enable
        if (r.full_s2)
            next_r.f.write_cache = 1'b0;
    end

    // state register with power-on defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.state <= IDLE;
            r.stat <= 8'h40;
            r.f.write_cache <= ATASF_RST_WC;
            r.f.look_ahead <= ATASF_RST_RLA;
            r.f.revert_defaults <= ATASF_RST_REV;
            r.f.release_irq <= ATASF_RST_REL;
            r.f.xfer_mode <= ATASF_RST_XFER;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign hrdata     = r.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign feat       = r.f;
    assign spinup_req = r.spin;
    assign cmd_done   = r.done;
endmodule : atasf_core

// ==== logic/atasf_pkg.sv ====
// constants, field layouts and carrier types of the sense and set-features block
// assumes an ahb-lite master, 32-bit data, word-aligned single transfers
// Function
// - temperature sense is F0h, feature 01h
// - other feature code aborts temperature sense
// - code 00h at or below minus twenty
// - codes 01h-FEh mean code/2 minus twenty
// - code FFh above 107 degrees
// - temperature sense runs in standby too
// - set features EFh, undefined code aborts
// - 02h write cache on, 82h off
// - 03h selects transfer mode from count
// - 05h power management on, 85h off
// - 06h/86h standby feature, 07h spin-up
// - 10h/90h serial option on/off
// - 43h sector time, 4Ah extended power
// - 55h look-ahead off, AAh on
// - 66h no reverting, CCh reverting on
// - reset: cache, look-ahead on; revert, release off
// - count: upper five type, low three mode
// - type 0 modes 0/1: default pio
// - type 1: flow pio modes 0-4
// - type 4 mdma 0-2, type 8 udma 0-6
// - reassignment exhausted disables write cache
// - later 02h succeeds but cache stays off
package atasf_pkg;
    // register byte offsets
    localparam logic [7:0] ATASF_OFS_COMMAND   = 8'h00; // wr: [7:0] opcode, [15:8] feature, [23:16] count
    localparam logic [7:0] ATASF_OFS_ERROR     = 8'h04; // command_error_flags
    localparam logic [7:0] ATASF_OFS_STATUS    = 8'h08; // command_status_flags
    localparam logic [7:0] ATASF_OFS_RESULT    = 8'h0c; // result sector count
    localparam logic [7:0] ATASF_OFS_FEATURES  = 8'h10; // feature state bits
    localparam logic [7:0] ATASF_OFS_XFER      = 8'h14; // selected transfer mode
    localparam logic [7:0] ATASF_OFS_SECTIME   = 8'h18; // wr/rd: host sector times
    // command fields
    localparam int ATASF_OPC_LSB = 0;
    localparam int ATASF_FEA_LSB = 8;
    localparam int ATASF_CNT_LSB = 16;
    // opcodes and codes
    localparam logic [7:0] ATASF_OPC_SENSE = 8'hf0;
    localparam logic [7:0] ATASF_OPC_SETF  = 8'hef;
    localparam logic [7:0] ATASF_SENSE_FEA = 8'h01;
    localparam logic [7:0] ATASF_F_WC_ON   = 8'h02;
    localparam logic [7:0] ATASF_F_XFER    = 8'h03;
    localparam logic [7:0] ATASF_F_APM_ON  = 8'h05;
    localparam logic [7:0] ATASF_F_PUIS_ON = 8'h06;
    localparam logic [7:0] ATASF_F_SPINUP  = 8'h07;
    localparam logic [7:0] ATASF_F_SATA_ON = 8'h10;
    localparam logic [7:0] ATASF_F_SECTIME = 8'h43;
    localparam logic [7:0] ATASF_F_EPC     = 8'h4a;
    localparam logic [7:0] ATASF_F_RLA_OFF = 8'h55;
    localparam logic [7:0] ATASF_F_REV_OFF = 8'h66;
    localparam logic [7:0] ATASF_F_WC_OFF  = 8'h82;
    localparam logic [7:0] ATASF_F_APM_OFF = 8'h85;
    localparam logic [7:0] ATASF_F_PUIS_OFF = 8'h86;
    localparam logic [7:0] ATASF_F_SATA_OFF = 8'h90;
    localparam logic [7:0] ATASF_F_RLA_ON  = 8'haa;
    localparam logic [7:0] ATASF_F_REV_ON  = 8'hcc;
    // transfer types and highest modes
    localparam logic [4:0] ATASF_XT_PIO  = 5'h00;
    localparam logic [4:0] ATASF_XT_FPIO = 5'h01;
    localparam logic [4:0] ATASF_XT_MDMA = 5'h04;
    localparam logic [4:0] ATASF_XT_UDMA = 5'h08;
    localparam logic [2:0] ATASF_PIO_MAX  = 3'h1;
    localparam logic [2:0] ATASF_FPIO_MAX = 3'h4;
    localparam logic [2:0] ATASF_MDMA_MAX = 3'h2;
    localparam logic [2:0] ATASF_UDMA_MAX = 3'h6;
    // temperature coding, half-degree steps above the offset
    localparam logic [7:0] ATASF_TEMP_LOW  = 8'h00;
    localparam logic [7:0] ATASF_TEMP_HIGH = 8'hff;
    localparam int         ATASF_TEMP_OFS  = 20;   // code = 2*(t+20)
    localparam int         ATASF_TEMP_MAX  = 107;
    // error and status bit positions
    localparam int ATASF_ERR_ABT = 2;
    localparam int ATASF_ST_BSY  = 7;
    localparam int ATASF_ST_RDY  = 6;
    localparam int ATASF_ST_ERR  = 0;
    // reset values of feature state
    localparam logic ATASF_RST_WC   = 1'b1;
    localparam logic ATASF_RST_RLA  = 1'b1;
    localparam logic ATASF_RST_REV  = 1'b0;
    localparam logic ATASF_RST_REL  = 1'b0;
    localparam logic [7:0] ATASF_RST_XFER = 8'h00;

    // feature state carried out of the block
    typedef struct packed {
        logic       write_cache;
        logic       look_ahead;
        logic       revert_defaults;
        logic       release_irq;
        logic       power_mgmt;
        logic       standby_powerup;
        logic       sata_option;
        logic       epc_select;
        logic [7:0] apm_level;
        logic [7:0] sata_code;
        logic [7:0] xfer_mode;
    } atasf_feat_t;

    // ahb-lite slave inputs
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } atasf_ahb_in_t;
endpackage : atasf_pkg

// ==== test/ata_sense_and_set_features_bench.sv ====
// self-checking bench of the sense and set-features block
// assumes the host model and the bound monitor
`timescale 1ns/10ps
module ata_sense_and_set_features_bench;
    import atasf_pkg::*;
    logic              hclk;
    logic              hresetn;
    logic              reassign_full;
    logic              spinup_req;
    logic              cmd_done;
    logic              hreadyout;
    logic              hresp;
    logic              seen_spin = 1'b0;
    logic signed [9:0] temp_deg;
    logic [31:0]       hrdata;
    logic [31:0]       q;
    atasf_ahb_in_t     ahb;
    atasf_feat_t       feat;
    int                errors = 0;
    int                cmp_count = 0;
    logic [7:0] fc [0:14] = '{8'hcc, 8'h66, 8'h82, 8'h55, 8'h05, 8'h85, 8'h10, 8'h90,
                              8'h4a, 8'h86, 8'h06, 8'h02, 8'haa, 8'h43, 8'h07};
    logic [7:0] fx [0:14] = '{8'he0, 8'hc0, 8'h40, 8'h00, 8'h08, 8'h00, 8'h02, 8'h00,
                              8'h01, 8'h01, 8'h05, 8'h85, 8'hc5, 8'hc5, 8'hc5};
    logic [7:0] xm [0:13] = '{8'h00, 8'h01, 8'h08, 8'h0c, 8'h20, 8'h22, 8'h40, 8'h46,
                              8'h02, 8'h0d, 8'h23, 8'h47, 8'h10, 8'h07};
    int         tv [0:6]  = '{-30, -20, -19, 0, 43, 107, 108};

    atasf_core atasf_core_inst (.hclk(hclk), .hresetn(hresetn), .ahb(ahb), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .temp_deg(temp_deg), .reassign_full(reassign_full),
        .feat(feat), .spinup_req(spinup_req), .cmd_done(cmd_done));
    atasf_host atasf_host_inst (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .ahb(ahb));

    // expected sensor code
    function automatic logic [7:0] tcode(input int t);
        if (t <= -20) return 8'h00;
        if (t > 107) return 8'hff;
        return 8'(2 * (t + 20));
    endfunction : tcode
    // masked register read and compare
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        atasf_host_inst.xfer(1'b0, a, 32'h0, q);
        cmp_count++;
        if ((q & m) !== e || hresp !== 1'b0) begin
            errors++;
            $display("unexpected at %0t: addr %h read %h wanted %h", $time, a, q & m, e);
        end
    endtask : chk
    // issue a command, then check error and status
    task automatic cmd(input logic [7:0] op, input logic [7:0] fe, input logic [7:0] cn, input logic ab);
        atasf_host_inst.xfer(1'b1, ATASF_OFS_COMMAND, {8'h0, cn, fe, op}, q);
        repeat (4) @(posedge hclk);
        chk(ATASF_OFS_ERROR, 32'hff, ab ? 32'h04 : 32'h00);
        chk(ATASF_OFS_STATUS, 32'hff, ab ? 32'h41 : 32'h40);
    endtask : cmd
    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // spin-up pulse catcher
    always @(posedge hclk) begin
        if (spinup_req === 1'b1) begin
            seen_spin <= 1'b1;
        end
    end
    // hang guard, about 5000 cycles
    initial begin
        #200000;
        errors++;
        $display("unexpected at %0t: run timed out", $time);
        stop_test();
    end
    // test sequence
    initial begin
        hresetn = 1'b0;
        reassign_full = 1'b0;
        temp_deg = 10'sd0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(ATASF_OFS_FEATURES, 32'hff, 32'hc0);
        chk(8'h40, 32'hffffffff, 32'h0);
        cmd(ATASF_OPC_SENSE, 8'h00, 8'h00, 1'b1);
        cmd(ATASF_OPC_SETF, 8'h00, 8'h00, 1'b1);
        cmd(8'h00, ATASF_SENSE_FEA, 8'h00, 1'b1);
        for (int i = 0; i < 15; i++) begin
            cmd(ATASF_OPC_SETF, fc[i], 8'h02, 1'b0);
            chk(ATASF_OFS_FEATURES, 32'hff, {24'h0, fx[i]});
        end
        chk(ATASF_OFS_FEATURES, 32'h00ffff00, 32'h00020200);
        chk(ATASF_OFS_SECTIME, 32'hff, 32'h02);
        atasf_host_inst.xfer(1'b1, ATASF_OFS_SECTIME, 32'h5a5a0302, q);
        chk(ATASF_OFS_SECTIME, 32'hffffffff, 32'h5a5a0302);
        cmp_count++;
        if (seen_spin !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no spin-up pulse seen", $time);
        end
        for (int i = 0; i < 7; i++) begin
            temp_deg <= 10'(tv[i]);
            cmd(ATASF_OPC_SENSE, ATASF_SENSE_FEA, 8'h00, 1'b0);
            chk(ATASF_OFS_RESULT, 32'hff, {24'h0, tcode(tv[i])});
        end
        for (int i = 0; i < 14; i++) begin
            cmd(ATASF_OPC_SETF, ATASF_F_XFER, xm[i], i > 7);
            chk(ATASF_OFS_XFER, 32'hff, {24'h0, (i < 8) ? xm[i] : xm[7]});
        end
        reassign_full <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(ATASF_OFS_FEATURES, 32'h80, 32'h0);
        cmd(ATASF_OPC_SETF, ATASF_F_WC_ON, 8'h00, 1'b0);
        chk(ATASF_OFS_FEATURES, 32'h80, 32'h0);
        // second reset in mid-run: defaults and unlocked cache return
        reassign_full <= 1'b0;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(ATASF_OFS_FEATURES, 32'hff, 32'hc0);
        chk(ATASF_OFS_XFER, 32'hff, 32'h0);
        stop_test();
    end
endmodule : ata_sense_and_set_features_bench

// ==== test/atasf_host.sv ====
// host controller model: ahb-lite master for single word transfers
// assumes a zero or more wait state slave whose hreadyout is hready
`timescale 1ns/10ps
module atasf_host
    import atasf_pkg::*;
(
    input  wire logic                     hclk,
    input  wire logic                     hreadyout,
    input  wire logic [31:0]              hrdata,
    output atasf_pkg::atasf_ahb_in_t      ahb
);
    // idle bus at time zero
    initial begin
        ahb.hsel   = 1'b0;
        ahb.haddr  = 32'h0;
        ahb.htrans = 2'h0;
        ahb.hwrite = 1'b0;
        ahb.hsize  = 3'h2;
        ahb.hwdata = 32'h0;
    end
    // single slave: its ready is the bus ready
    always @* ahb.hready = hreadyout;
    // one transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        ahb.hsel   <= 1'b1;
        ahb.haddr  <= {24'h0, a};
        ahb.htrans <= 2'h2;
        ahb.hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        ahb.htrans <= 2'h0;
        ahb.hsel   <= 1'b0;
        ahb.hwdata <= wr ? d : ~d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
endmodule : atasf_host

// ==== test/atasf_monitor.sv ====
// port assertions of the sense and set-features block
// assumes it is bound onto atasf_core, one clock domain
`timescale 1ns/10ps
module atasf_monitor
    import atasf_pkg::*;
(
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire atasf_pkg::atasf_ahb_in_t ahb,
    input wire logic                     reassign_full,
    input wire atasf_pkg::atasf_feat_t   feat,
    input wire logic                     spinup_req,
    input wire logic                     cmd_done
);
    logic cmd_wr;
    logic seen_full;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // command word address phase
    assign cmd_wr = ahb.hsel && ahb.hready && ahb.htrans[1] && ahb.hwrite && ahb.haddr[7:0] == ATASF_OFS_COMMAND;
    // sticky until reset, the cache lock never lifts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_full <= 1'b0;
        end else if (reassign_full) begin
            seen_full <= 1'b1;
        end
    end
    AST_RESET_DEFAULTS: assert property ($rose(hresetn) |-> feat.write_cache && feat.look_ahead
        && !feat.revert_defaults && !feat.release_irq) else $error("defaults wrong after reset");
    AST_DONE_AFTER_CMD: assert property (cmd_wr |-> ##[2:4] cmd_done) else $error("command never done");
    AST_DONE_PULSE: assert property (cmd_done |=> !cmd_done) else $error("done longer than a cycle");
    AST_SPINUP_PULSE: assert property (spinup_req |=> !spinup_req) else $error("spin-up not a pulse");
    AST_WC_ON: assert property (cmd_wr ##1 (ahb.hwdata[15:0] == 16'h02ef && !seen_full)
        |-> ##[1:3] feat.write_cache) else $error("cache not enabled");
    AST_WC_OFF: assert property (cmd_wr ##1 ahb.hwdata[15:0] == 16'h82ef
        |-> ##[1:3] !feat.write_cache) else $error("cache not disabled");
    AST_RLA_OFF: assert property (cmd_wr ##1 ahb.hwdata[15:0] == 16'h55ef
        |-> ##[1:3] !feat.look_ahead) else $error("look-ahead not disabled");
    AST_PUIS_ON: assert property (cmd_wr ##1 ahb.hwdata[15:0] == 16'h06ef
        |-> ##[1:3] feat.standby_powerup) else $error("standby feature not enabled");
    AST_CACHE_LOCK: assert property (reassign_full [*5] |-> !feat.write_cache)
        else $error("cache on with pool full");
endmodule : atasf_monitor

bind atasf_core atasf_monitor atasf_monitor_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .ahb(ahb),
    .reassign_full(reassign_full),
    .feat(feat),
    .spinup_req(spinup_req),
    .cmd_done(cmd_done)
);
